//--- design/psq_pkg.sv
// Purpose: Constants, states and carriers of the supply sequencer
// Assumes: 25 MHz system clock, voltages in 0.1 V units
// Notes:   Byte addresses of the register port are word aligned
package psq_pkg;
    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int         CLK_HZ      = 25_000_000;
    localparam int         SEC_PER_MIN = 60;
    localparam logic [2:0] VOLT_HOLD_S = 3'd5;
    localparam logic [2:0] BTN_OFF_S   = 3'd4;
    localparam logic [2:0] BTN_ON_S    = 3'd2;
    // -------------------------------------------------------------
    // Voltage thresholds, 0.1 V per step
    // -------------------------------------------------------------
    localparam logic [9:0] V_WALL_OFF  = 10'h03c;
    localparam logic [9:0] V_WALL_ON   = 10'h03e;
    localparam logic [9:0] V_HYST      = 10'h002;
    localparam logic [9:0] MINV_RST    = 10'h03c;
    // -------------------------------------------------------------
    // Register byte addresses
    // -------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_MINV = 8'h08;
    localparam logic [7:0] A_HALT = 8'h0c;
    localparam logic [7:0] A_BOOT = 8'h10;
    localparam logic [7:0] A_RSTM = 8'h14;
    localparam logic [7:0] A_WDOG = 8'h18;
    localparam logic [7:0] A_WAKE = 8'h1c;
    localparam logic [7:0] A_TIME = 8'h20;
    localparam logic [7:0] A_DATE = 8'h24;
    localparam logic [7:0] A_BSEL = 8'h28;
    localparam logic [7:0] A_BDAT = 8'h2c;
    // Control bits
    localparam int C_CUTBUS  = 0;
    localparam int C_BTNDIS  = 1;
    localparam int C_DATEPSH = 2;
    localparam int C_PWROFF  = 8;
    localparam int C_KICK    = 9;
    // -------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------
    localparam logic [7:0] HALT_RST = 8'h1e;
    localparam logic [7:0] BOOT_RST = 8'h1e;
    localparam logic [6:0] YEAR_RST = 7'h01;
    localparam logic [3:0] MON_RST  = 4'h1;
    localparam logic [4:0] DAY_RST  = 5'h01;
    localparam logic [5:0] LAST_ADR = 6'h3f;
    localparam logic [5:0] FIRST_ADR = 6'h01;

    typedef enum {
        ST_BOOT, ST_DATE, ST_DISC, ST_ON, ST_NOTIFY, ST_HALT, ST_SLEEP
    } psq_state_e;

    typedef struct packed {
        logic       wr;
        logic [5:0] addr;
        logic [7:0] data;
    } psq_poll_s;
endpackage

//--- design/psq_ups_sequencer.sv
// Purpose: On/Sleep sequencer, clock and board poller of a backed supply
// Assumes: Voltage words are sampled and stable for several clocks
// Notes:   Second and minute ticks come from a divider of sys_clk
//
// Summary of operation
// RULE_01: Closed jumper selects wall mode, open jumper battery mode thresholds.
// RULE_02: Wall mode, On: wall below battery over five seconds sends shutdown.
// RULE_03: Wall mode, On: wall below 6 V over 5 seconds powers off.
// RULE_04: Battery mode: battery below low threshold over five seconds; wall ignored.
// RULE_05: Battery low threshold resets to 6 V, host may change it.
// RULE_06: After shutdown, wait halt time then cut host and bus power.
// RULE_07: On power-on, ignore power conditions until boot time elapses.
// RULE_08: On: button held over 4 s powers off unless disabled.
// RULE_09: Host power-off command starts the power-off process.
// RULE_10: Watchdog enabled and not kicked for set seconds starts power-off.
// RULE_11: Off order: shutdown, optional early bus cut, halt wait, cut, Sleep.
// RULE_12: Sleep: wall over 6.2 V or battery over threshold+0.2 for 5 s.
// RULE_13: Sleep: button held over 2 s powers on unless disabled.
// RULE_14: Restart delay set: power on that many minutes after entering Sleep.
// RULE_15: Scheduled wake day, hour, minute equal to clock powers on.
// RULE_16: On order: supplies up, boot wait, optional date push, discovery, On.
// RULE_17: On state accepts date, restart, wake, watchdog and board commands; watchdog time writes are taken in every state.
// RULE_18: Clock runs always, starts 1/1/2001 00:00:00, host may overwrite.
// RULE_19: First wake and every On entry poll all 63 addresses.
// RULE_20: Idle: keep polling known boards into a local value table.
// RULE_21: Host writes go first, after only the poll in progress.
// RULE_22: Unknown address answers not-present at once and is probed once.
// RULE_23: Second and minute ticks drive all hold and wait timers.
// RULE_24: A timed condition restarts its count when it goes false.
module psq_ups_sequencer #(
    parameter int SEC_CYC = psq_pkg::CLK_HZ
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              modeJumperClosed,
    input  wire logic [9:0]        wallVolt,
    input  wire logic [9:0]        battVolt,
    input  wire logic              button_n,
    input  wire logic [7:0]        regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [31:0]       regRdata,
    output logic                   hostPowerEn,
    output logic                   busPowerEn,
    output logic                   shutdownCmd,
    output logic                   datePush,
    output logic                   pollStart,
    output psq_pkg::psq_poll_s     pollReq,
    input  wire logic              pollDone,
    input  wire logic              pollAnswered,
    input  wire logic [7:0]        pollRdata
);
    import psq_pkg::*;

    if (SEC_CYC < 2)
    begin : g_secCycChk
        $error("SEC_CYC too small");
    end

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [21:0] syncA_ff;
    logic [21:0] syncB_ff;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncA_ff <= '1;
            syncB_ff <= '1;
        end
        else
        begin
            syncA_ff <= {modeJumperClosed, button_n, wallVolt, battVolt};
            syncB_ff <= syncA_ff;
        end
    end
    // Mode select
    // RULE_01: jumper decides mode
    wire       wallMode = syncB_ff[21];
    wire       btnHeld  = !syncB_ff[20];
    wire [9:0] wallV    = syncB_ff[19:10];
    wire [9:0] battV    = syncB_ff[9:0];

    // ---------------------------------------------------------------
    // Tick divider
    // ---------------------------------------------------------------
    // RULE_23: derived time base
    logic [31:0] divCnt_ff;
    logic [5:0]  secInMin_ff;
    wire         secTick = (divCnt_ff == 32'(SEC_CYC - 1));
    wire         minTick = secTick && (secInMin_ff == 6'(SEC_PER_MIN - 1));
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divCnt_ff   <= '0;
            secInMin_ff <= '0;
        end
        else
        begin
            divCnt_ff <= secTick ? '0 : divCnt_ff + 32'h1;
            if (secTick)
                secInMin_ff <= minTick ? '0 : secInMin_ff + 6'h1;
        end
    end

    // ---------------------------------------------------------------
    // Registers and state
    // ---------------------------------------------------------------
    psq_state_e  state_ff;
    logic [2:0]  ctrl_ff;
    logic [9:0]  minVolt_ff;
    logic [7:0]  haltWait_ff;
    logic [7:0]  bootWait_ff;
    logic [15:0] restartMin_ff;
    logic [15:0] wdogSec_ff;
    logic [16:0] wake_ff;
    logic [5:0]  rtcSec_ff;
    logic [5:0]  rtcMin_ff;
    logic [4:0]  rtcHour_ff;
    logic [4:0]  rtcDay_ff;
    logic [3:0]  rtcMon_ff;
    logic [6:0]  rtcYear_ff;
    logic [5:0]  boardSel_ff;
    logic        notPresErr_ff;
    logic [7:0]  stateSec_ff;
    logic [15:0] sleepMin_ff;
    logic [15:0] wdogCnt_ff;
    logic [63:0] present_ff;
    logic [7:0]  valTab [0:63];

    wire isOn    = (state_ff == ST_ON);
    wire isSleep = (state_ff == ST_SLEEP);
    wire wrHit   = regWr;
    wire wrCtrl  = wrHit && regAddr == A_CTRL;
    // RULE_17: On-only commands
    wire wrOnCmd = wrHit && isOn;
    wire pwrOffCmd = wrCtrl && regWdata[C_PWROFF];
    wire kick      = wrCtrl && regWdata[C_KICK];
    wire selPres   = present_ff[boardSel_ff];
    wire bdatRd    = regRd && regAddr == A_BDAT && isOn;
    wire bdatWr    = wrOnCmd && regAddr == A_BDAT;

    // ---------------------------------------------------------------
    // Timed conditions
    // ---------------------------------------------------------------
    // RULE_02: wall below battery
    // RULE_03: wall below fixed floor
    // RULE_04: battery below threshold
    wire offVolt = wallMode ? (wallV < battV || wallV < V_WALL_OFF)
                            : (battV < minVolt_ff);
    // RULE_12: recovery levels
    wire onVolt  = wallMode ? (wallV > V_WALL_ON)
                            : (battV > minVolt_ff + V_HYST);
    wire btnOk   = btnHeld && !ctrl_ff[C_BTNDIS];
    wire [3:0] holdCond = {btnOk && isSleep, btnOk && isOn,
                           onVolt && isSleep, offVolt && isOn};
    localparam logic [3:0][2:0] HOLD_LIM =
        {BTN_ON_S, BTN_OFF_S, VOLT_HOLD_S, VOLT_HOLD_S};
    wire [3:0] holdFire;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_hold
            logic [2:0] cnt_ff;
            // RULE_24: restart when false
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    cnt_ff <= '0;
                else if (!holdCond[gi])
                    cnt_ff <= '0;
                else if (secTick && cnt_ff != 3'h7)
                    cnt_ff <= cnt_ff + 3'h1;
            end
            assign holdFire[gi] = holdCond[gi] && (cnt_ff > HOLD_LIM[gi]);
        end
    endgenerate

    // RULE_10: watchdog expiry
    wire wdogFire = wdogSec_ff != '0 && wdogCnt_ff >= wdogSec_ff;
    // RULE_14: restart delay
    wire rstFire  = restartMin_ff != '0 && sleepMin_ff >= restartMin_ff;
    // RULE_15: scheduled wake match
    wire wakeFire = wake_ff[16] && rtcSec_ff == '0 &&
                    wake_ff[15:0] == {rtcDay_ff, rtcHour_ff, rtcMin_ff};
    // RULE_08: button off
    // RULE_09: host power-off
    wire offTrig  = isOn && (holdFire[0] || holdFire[2] || pwrOffCmd || wdogFire);
    // RULE_13: button on
    wire onTrig   = isSleep && (holdFire[1] || holdFire[3] || rstFire || wakeFire);

    // ---------------------------------------------------------------
    // Board poller
    // ---------------------------------------------------------------
    logic       busy_ff;
    logic       discAct_ff;
    logic [5:0] discPtr_ff;
    logic       discWrap_ff;
    logic [5:0] scanPtr_ff;
    logic       pendV_ff;
    psq_poll_s  pend_ff;
    logic       probeV_ff;
    logic [5:0] probeAdr_ff;
    logic       pollStart_ff;
    psq_poll_s  pollReq_ff;
    wire pollOk   = busPowerEn && (isOn || state_ff == ST_DISC);
    wire canIssue = pollOk && !busy_ff;
    // RULE_21: write first, then probe, sweep, scan
    wire issPend  = canIssue && pendV_ff;
    wire issProbe = canIssue && !pendV_ff && probeV_ff;
    wire issDisc  = canIssue && !pendV_ff && !probeV_ff && discAct_ff && !discWrap_ff;
    wire issScan  = canIssue && !pendV_ff && !probeV_ff && !discAct_ff &&
                    present_ff[scanPtr_ff];
    wire [5:0] issAdr = issPend ? pend_ff.addr : issProbe ? probeAdr_ff :
                        issDisc ? discPtr_ff : scanPtr_ff;
    wire issAny   = issPend || issProbe || issDisc || issScan;
    wire discDone = discAct_ff && discWrap_ff && !busy_ff && state_ff == ST_DISC;
    // RULE_22: unknown address probed once
    wire needProbe = (bdatRd || bdatWr) && !selPres;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_ff      <= 1'b0;
            discAct_ff   <= 1'b0;
            discPtr_ff   <= FIRST_ADR;
            discWrap_ff  <= 1'b0;
            scanPtr_ff   <= FIRST_ADR;
            pendV_ff     <= 1'b0;
            pend_ff      <= '0;
            probeV_ff    <= 1'b0;
            probeAdr_ff  <= '0;
            pollStart_ff <= 1'b0;
            pollReq_ff   <= '0;
            present_ff   <= '0;
        end
        else
        begin
            pollStart_ff <= issAny;
            if (issAny)
            begin
                busy_ff    <= 1'b1;
                pollReq_ff <= '{wr: issPend, addr: issAdr, data: pend_ff.data};
            end
            else if (pollDone)
                busy_ff <= 1'b0;
            if (pollDone && busy_ff)
                present_ff[pollReq_ff.addr] <= pollAnswered;
            // RULE_19: full sweep on wake and On entry
            if (state_ff == ST_DATE && !discAct_ff)
            begin
                discAct_ff  <= 1'b1;
                discPtr_ff  <= FIRST_ADR;
                discWrap_ff <= 1'b0;
            end
            else if (issDisc)
            begin
                discPtr_ff <= discPtr_ff + 6'h1;
                if (discPtr_ff == LAST_ADR)
                    discWrap_ff <= 1'b1;
            end
            else if (discDone)
                discAct_ff <= 1'b0;
            // RULE_20: idle scan of known boards
            if (issScan || (canIssue && !issAny))
                scanPtr_ff <= (scanPtr_ff == LAST_ADR) ? FIRST_ADR
                                                       : scanPtr_ff + 6'h1;
            if (bdatWr && selPres)
            begin
                pendV_ff <= 1'b1;
                pend_ff  <= '{wr: 1'b1, addr: boardSel_ff, data: regWdata[7:0]};
            end
            else if (issPend)
                pendV_ff <= 1'b0;
            if (needProbe)
            begin
                probeV_ff   <= 1'b1;
                probeAdr_ff <= boardSel_ff;
            end
            else if (issProbe)
                probeV_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (pollDone && busy_ff && pollAnswered && !pollReq_ff.wr)
            valTab[pollReq_ff.addr] <= pollRdata;
    end

    // ---------------------------------------------------------------
    // Real-time clock
    // ---------------------------------------------------------------
    wire leap = rtcYear_ff[1:0] == 2'h0;
    wire [4:0] monLast = (rtcMon_ff == 4'h2) ? (leap ? 5'h1d : 5'h1c) :
                         (rtcMon_ff == 4'h4 || rtcMon_ff == 4'h6 ||
                          rtcMon_ff == 4'h9 || rtcMon_ff == 4'hb) ? 5'h1e : 5'h1f;
    wire rtcRoll = secTick && rtcSec_ff == 6'(SEC_PER_MIN - 1);
    wire dayEnd = rtcRoll && rtcMin_ff == 6'h3b && rtcHour_ff == 5'h17;
    // RULE_18: free-running calendar
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {rtcSec_ff, rtcMin_ff, rtcHour_ff} <= '0;
            rtcDay_ff  <= DAY_RST;
            rtcMon_ff  <= MON_RST;
            rtcYear_ff <= YEAR_RST;
        end
        else if (wrOnCmd && regAddr == A_TIME)
            {rtcDay_ff, rtcHour_ff, rtcMin_ff, rtcSec_ff} <= regWdata[21:0];
        else if (wrOnCmd && regAddr == A_DATE)
            {rtcYear_ff, rtcMon_ff} <= regWdata[10:0];
        else if (secTick)
        begin
            rtcSec_ff <= rtcRoll ? '0 : rtcSec_ff + 6'h1;
            if (rtcRoll)
                rtcMin_ff <= (rtcMin_ff == 6'h3b) ? '0 : rtcMin_ff + 6'h1;
            if (rtcRoll && rtcMin_ff == 6'h3b)
                rtcHour_ff <= (rtcHour_ff == 5'h17) ? '0 : rtcHour_ff + 5'h1;
            if (dayEnd)
                rtcDay_ff <= (rtcDay_ff == monLast) ? DAY_RST : rtcDay_ff + 5'h1;
            if (dayEnd && rtcDay_ff == monLast)
                rtcMon_ff <= (rtcMon_ff == 4'hc) ? MON_RST : rtcMon_ff + 4'h1;
            if (dayEnd && rtcDay_ff == monLast && rtcMon_ff == 4'hc)
                rtcYear_ff <= rtcYear_ff + 7'h1;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    psq_state_e nxt_state;
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            // RULE_07: boot wait ignores conditions
            ST_BOOT:   if (stateSec_ff >= bootWait_ff) nxt_state = ST_DATE;
            ST_DATE:   nxt_state = ST_DISC;
            ST_DISC:   if (discDone) nxt_state = ST_ON;
            ST_ON:     if (offTrig) nxt_state = ST_NOTIFY;
            ST_NOTIFY: nxt_state = ST_HALT;
            // RULE_06: halt wait ignores conditions
            ST_HALT:   if (stateSec_ff >= haltWait_ff) nxt_state = ST_SLEEP;
            ST_SLEEP:  if (onTrig) nxt_state = ST_BOOT;
            default:   nxt_state = ST_SLEEP;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff    <= ST_BOOT;
            stateSec_ff <= '0;
            hostPowerEn <= 1'b1;
            busPowerEn  <= 1'b1;
            shutdownCmd <= 1'b0;
            datePush    <= 1'b0;
            sleepMin_ff <= '0;
            wdogCnt_ff  <= '0;
        end
        else
        begin
            state_ff    <= nxt_state;
            stateSec_ff <= (nxt_state != state_ff) ? '0 :
                           (secTick && stateSec_ff != 8'hff) ? stateSec_ff + 8'h1
                                                            : stateSec_ff;
            // RULE_11: shutdown then optional early bus cut
            shutdownCmd <= (nxt_state == ST_NOTIFY && state_ff == ST_ON);
            if (state_ff == ST_NOTIFY && ctrl_ff[C_CUTBUS])
                busPowerEn <= 1'b0;
            if (nxt_state == ST_SLEEP && state_ff == ST_HALT)
            begin
                hostPowerEn <= 1'b0;
                busPowerEn  <= 1'b0;
            end
            // RULE_16: supplies up first
            if (nxt_state == ST_BOOT && state_ff == ST_SLEEP)
            begin
                hostPowerEn <= 1'b1;
                busPowerEn  <= 1'b1;
            end
            datePush    <= (state_ff == ST_DATE) && ctrl_ff[C_DATEPSH];
            sleepMin_ff <= !isSleep ? '0 :
                           (minTick && sleepMin_ff != 16'hffff) ? sleepMin_ff + 16'h1
                                                                : sleepMin_ff;
            wdogCnt_ff  <= (!isOn || kick) ? '0 :
                           (secTick && wdogCnt_ff != 16'hffff) ? wdogCnt_ff + 16'h1
                                                               : wdogCnt_ff;
        end
    end

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ff       <= '0;
            // RULE_05: threshold default
            minVolt_ff    <= MINV_RST;
            haltWait_ff   <= HALT_RST;
            bootWait_ff   <= BOOT_RST;
            restartMin_ff <= '0;
            wdogSec_ff    <= '0;
            wake_ff       <= '0;
            boardSel_ff   <= '0;
            notPresErr_ff <= 1'b0;
        end
        else
        begin
            if (wrCtrl)
                ctrl_ff <= regWdata[2:0];
            if (wrHit && regAddr == A_MINV)
                minVolt_ff <= regWdata[9:0];
            if (wrHit && regAddr == A_HALT)
                haltWait_ff <= regWdata[7:0];
            if (wrHit && regAddr == A_BOOT)
                bootWait_ff <= regWdata[7:0];
            if (wrOnCmd && regAddr == A_RSTM)
                restartMin_ff <= regWdata[15:0];
            if (wrHit && regAddr == A_WDOG)
                wdogSec_ff <= regWdata[15:0];
            if (wrOnCmd && regAddr == A_WAKE)
                wake_ff <= regWdata[16:0];
            if (wrHit && regAddr == A_BSEL)
                boardSel_ff <= regWdata[5:0];
            if (needProbe)
                notPresErr_ff <= 1'b1;
            else if (regRd && regAddr == A_STAT)
                notPresErr_ff <= 1'b0;
        end
    end

    wire [31:0] statWord = {24'h0, notPresErr_ff, wallMode, busPowerEn,
                            hostPowerEn, 1'b0, 3'(state_ff)};
    wire [31:0] rdMux =
        (regAddr == A_CTRL) ? {29'h0, ctrl_ff} :
        (regAddr == A_STAT) ? statWord :
        (regAddr == A_MINV) ? {22'h0, minVolt_ff} :
        (regAddr == A_HALT) ? {24'h0, haltWait_ff} :
        (regAddr == A_BOOT) ? {24'h0, bootWait_ff} :
        (regAddr == A_RSTM) ? {16'h0, restartMin_ff} :
        (regAddr == A_WDOG) ? {16'h0, wdogSec_ff} :
        (regAddr == A_WAKE) ? {15'h0, wake_ff} :
        (regAddr == A_TIME) ? {10'h0, rtcDay_ff, rtcHour_ff, rtcMin_ff, rtcSec_ff} :
        (regAddr == A_DATE) ? {21'h0, rtcYear_ff, rtcMon_ff} :
        (regAddr == A_BSEL) ? {26'h0, boardSel_ff} :
        (regAddr == A_BDAT) ? {23'h0, selPres, valTab[boardSel_ff]} : 32'h0;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            regRdata <= '0;
        else
            regRdata <= regRd ? rdMux : 32'h0;
    end

    assign pollStart = pollStart_ff;
    assign pollReq   = pollReq_ff;
endmodule // psq_ups_sequencer

//--- tb/psq_bus_model.sv
// Purpose: Expansion bus transactor model
// Assumes: One board present at address 5
// Notes:   Idle answer lines toggle every cycle
module psq_bus_model (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               pollStart,
    input  wire psq_pkg::psq_poll_s pollReq,
    output logic                    pollDone,
    output logic                    pollAnswered,
    output logic [7:0]              pollRdata
);
    import psq_pkg::*;
    logic [2:0] cnt_ff;
    wire        fin = (cnt_ff == 3'h1);
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            cnt_ff <= 3'h0;
        else
            cnt_ff <= pollStart ? {pollReq.addr[0], 2'h2} : cnt_ff - 3'(cnt_ff != 3'h0);
    always_ff @(posedge sys_clk)
    begin
        pollDone <= fin;
        pollAnswered <= fin ? (pollReq.addr == 6'h05) : ~pollAnswered;
        pollRdata <= fin ? 8'ha5 : ~pollRdata;
    end
endmodule // psq_bus_model

//--- tb/psq_checker.sv
// Purpose: Port assertions of the supply sequencer
// Assumes: One clock, async active-low reset
// Notes:   Bound to the sequencer module
module psq_checker (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic        hostPowerEn,
    input wire logic        busPowerEn,
    input wire logic        shutdownCmd,
    input wire logic        datePush,
    input wire logic        pollStart
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_rdIdle; !$past(regRd) |-> regRdata == 32'h0; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("stray rdata");
    property p_shutPulse; shutdownCmd |=> !shutdownCmd; endproperty
    a_shutPulse: assert property (p_shutPulse) else $error("long shutdown");
    property p_shutHold; shutdownCmd |=> hostPowerEn [*8]; endproperty
    a_shutHold: assert property (p_shutHold) else $error("early cut");
    property p_busHost; busPowerEn |-> hostPowerEn; endproperty
    a_busHost: assert property (p_busHost) else $error("bus without host");
    property p_riseBoth; $rose(hostPowerEn) |-> busPowerEn; endproperty
    a_riseBoth: assert property (p_riseBoth) else $error("bus not raised");
    property p_dateUp; datePush |-> hostPowerEn && busPowerEn; endproperty
    a_dateUp: assert property (p_dateUp) else $error("push unpowered");
    property p_pollPulse; pollStart |=> !pollStart; endproperty
    a_pollPulse: assert property (p_pollPulse) else $error("long poll");
    property p_pollPower; pollStart |-> busPowerEn; endproperty
    a_pollPower: assert property (p_pollPower) else $error("poll unpowered");
endmodule // psq_checker
bind psq_ups_sequencer psq_checker psq_checker_i (.sys_clk, .rst_n, .regRd, .regRdata,
    .hostPowerEn, .busPowerEn, .shutdownCmd, .datePush, .pollStart);

//--- tb/psq_ups_sequencer_tb.sv
// Purpose: Register-level test of the supply sequencer
// Assumes: Short second tick, wall mode
// Notes:   Runs boot, board access, off and on cycles
module psq_ups_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import psq_pkg::*;
    localparam int SEC = 20;
    logic        sys_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, button_n = 1'b1;
    logic [7:0]  regAddr = 8'h00, pollRdata;
    logic [31:0] regWdata = 32'h0, regRdata, v;
    logic [9:0]  wallVolt = 10'h046;
    logic        hostPowerEn, busPowerEn, shutdownCmd, datePush, pollStart;
    logic        pollDone, pollAnswered;
    psq_poll_s   pollReq;
    int          err_count = 0, checks_done = 0, pushes = 0, n;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (datePush === 1'b1) pushes++;
    psq_ups_sequencer #(.SEC_CYC(SEC)) psq_ups_sequencer_i (.sys_clk, .rst_n,
        .modeJumperClosed(1'b1), .wallVolt, .battVolt(10'h046), .button_n,
        .regAddr, .regWdata, .regWr, .regRd, .regRdata, .hostPowerEn, .busPowerEn,
        .shutdownCmd, .datePush, .pollStart, .pollReq, .pollDone, .pollAnswered, .pollRdata);
    psq_bus_model psq_bus_model_i (.sys_clk, .rst_n, .pollStart, .pollReq, .pollDone,
        .pollAnswered, .pollRdata);
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task tick(input int lim);
        @(posedge sys_clk);
        #1 n++;
        if (n > lim)
        begin
            chk(32'h0, 32'h1);
            stop_test;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input bit c);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 v = regRdata;
        if (c)
            chk(v & m, e);
    endtask
    task waitOn;
        n = 0;
        rd(A_STAT, 0, 0, 0);
        while (v[2:0] !== 3'd3)
        begin
            rd(A_STAT, 0, 0, 0);
            if (n++ > 4000) tick(0);
        end
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(A_STAT, 32'h37, 32'h30, 1);
        rd(A_MINV, 32'h3ff, 32'h03c, 1);
        rd(8'h30, 32'hffffffff, 32'h0, 1);
        rd(A_DATE, 32'h7ff, 32'h011, 1);
        wr(A_HALT, 32'h2);
        wr(A_BOOT, 32'h2);
        wr(A_CTRL, 32'h4);
        waitOn;
        $display("boot done");
        rd(A_STAT, 32'h40, 32'h40, 1);
        wr(A_BSEL, 32'h05);
        rd(A_BDAT, 32'h1ff, 32'h1a5, 1);
        wr(A_BSEL, 32'h09);
        rd(A_BDAT, 32'h100, 32'h0, 1);
        rd(A_STAT, 32'h80, 32'h80, 1);
        @(posedge sys_clk);
        wallVolt <= 10'h032;
        n = 0;
        while (shutdownCmd !== 1'b1) tick(3000);
        chk(32'(n > 5 * SEC), 32'h1);
        n = 0;
        while (hostPowerEn !== 1'b0) tick(3000);
        chk(32'(n > SEC), 32'h1);
        rd(A_STAT, 32'h37, 32'h06, 1);
        $display("off done");
        @(posedge sys_clk);
        wallVolt <= 10'h050;
        n = 0;
        while (hostPowerEn !== 1'b1) tick(3000);
        chk(32'(n > 5 * SEC), 32'h1);
        waitOn;
        chk(32'(pushes), 32'h2);
        @(posedge sys_clk);
        button_n <= 1'b0;
        n = 0;
        while (shutdownCmd !== 1'b1) tick(3000);
        chk(32'(n > 4 * SEC), 32'h1);
        n = 0;
        while (hostPowerEn !== 1'b0) tick(3000);
        while (hostPowerEn !== 1'b1) tick(3000);
        @(posedge sys_clk);
        button_n <= 1'b1;
        waitOn;
        $display("button done");
        wr(A_CTRL, 32'h104);
        #1 chk(32'(shutdownCmd), 32'h1);
        stop_test;
    end
endmodule // psq_ups_sequencer_tb
